// *** src/pvt_pkg.sv ***
package pvt_pkg;

    // ------------------------------------------------------------
    // pixel word carried to the panel
    // ------------------------------------------------------------
    localparam int CHAN_W = 8;
    localparam int RGB_W = 3 * CHAN_W;

    typedef struct packed {
        logic [CHAN_W-1:0] red;
        logic [CHAN_W-1:0] green;
        logic [CHAN_W-1:0] blue;
    } pvt_rgb_t;

    typedef struct packed {
        logic strobe;
        pvt_rgb_t rgb;
    } pvt_pix_t;

    localparam pvt_rgb_t RGB_BLACK = '{red: 8'h00, green: 8'h00, blue: 8'h00};
    localparam pvt_pix_t PIX_RESET = '{strobe: 1'b0, rgb: RGB_BLACK};

    // ------------------------------------------------------------
    // line and frame timing, in pixel clocks, lines and microseconds
    // ------------------------------------------------------------
    localparam int LINE_ACTIVE_SPAN = 960;
    localparam int HBLANK_MIN = 80;
    localparam int HBLANK_NOM = 140;
    localparam int HBLANK_MAX = 445;
    localparam int LINE_PERIOD_TOTAL_NOM = 1100;
    localparam real LINE_PERIOD_US_NOM = 14.8;
    localparam int FRAME_ACTIVE_LINES = 1080;
    localparam int VBLANK_MIN = 31;
    localparam int VBLANK_NOM = 45;

    // ------------------------------------------------------------
    // pixel clock and frame period limits
    // ------------------------------------------------------------
    localparam real PIXEL_CLOCK_MHZ_MIN = 60.0;
    localparam real PIXEL_CLOCK_MHZ_NOM = 74.25;
    localparam real PIXEL_CLOCK_MHZ_MAX = 80.0;
    localparam real FRAME_PERIOD_MS_MIN = 16.5;
    localparam real FRAME_PERIOD_MS_NOM = 16.67;
    localparam real FRAME_PERIOD_MS_MAX = 23.1;
    localparam real FRAME_RATE_HZ_NOM = 60.0;
    localparam real FRAME_RATE_HZ_MAX = 60.6;

    // ------------------------------------------------------------
    // local clock, counter widths and buffer depth
    // ------------------------------------------------------------
    localparam int REF_CLK_HZ = 10_000_000;
    localparam int PIX_CNT_W = 11;
    localparam int LINE_CNT_W = 12;
    localparam int FIFO_DEPTH = 2;

endpackage

// *** src/pvt_video_source.sv ***
// Summary of operation
// - pixel clock runs between 60 and 80 MHz, nominally 74.25 MHz.
// - strobe stays high exactly 960 pixel clocks per line, one pixel each.
// - horizontal blanking lasts 80 to 445 pixel clocks, nominally 140.
// - nominal line period is 1100 pixel clocks, about 14.8 us.
// - every frame carries exactly 1080 lines with the strobe asserted.
// - vertical blanking lasts at least 31 whole lines, nominally 45.
// - frame period lies between 16.5 ms and 23.1 ms, nominally 16.67 ms.
// - frame rate stays at or below 60.6 Hz, nominally 60 Hz.
// - each frame period is a whole number of line periods.
// - show a black image before the panel is switched off.
// - strobe toggles every active line and is never held permanently high.
// - three 8-bit channels form each 24-bit pixel, red green blue.
module pvt_video_source #(
    parameter int ACTIVE_SPAN = pvt_pkg::LINE_ACTIVE_SPAN,
    parameter int HBLANK = pvt_pkg::HBLANK_NOM,
    parameter int ACTIVE_LINES = pvt_pkg::FRAME_ACTIVE_LINES,
    parameter int VBLANK = pvt_pkg::VBLANK_NOM,
    parameter real PIXEL_CLOCK_MHZ = pvt_pkg::PIXEL_CLOCK_MHZ_NOM,
    parameter int FIFO_W = pvt_pkg::RGB_W,
    parameter int FIFO_D = pvt_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic blackReq,
    input wire logic [FIFO_W-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic pixelClk,
    output pvt_pkg::pvt_pix_t pixOut,
    output logic underrun,
    output logic blackDone
);

    // ------------------------------------------------------------
    // elaboration checks on the timing figures
    // ------------------------------------------------------------
    localparam int LINE_TOTAL = ACTIVE_SPAN + HBLANK;
    localparam int FRAME_LINES = ACTIVE_LINES + VBLANK;
    // whole lines only: the frame is counted in lines, never in loose pixels
    localparam real FRAME_MS = real'(LINE_TOTAL) * real'(FRAME_LINES) / (PIXEL_CLOCK_MHZ * 1000.0);
    localparam real FRAME_HZ = 1000.0 / FRAME_MS;

    generate
        if (PIXEL_CLOCK_MHZ < pvt_pkg::PIXEL_CLOCK_MHZ_MIN ||
            PIXEL_CLOCK_MHZ > pvt_pkg::PIXEL_CLOCK_MHZ_MAX) begin : gBadClk
            $error("pixel clock out of range");
        end
        if (ACTIVE_SPAN != pvt_pkg::LINE_ACTIVE_SPAN) begin : gBadSpan
            $error("active span must be 960");
        end
        if (HBLANK < pvt_pkg::HBLANK_MIN || HBLANK > pvt_pkg::HBLANK_MAX) begin : gBadHb
            $error("horizontal blanking out of range");
        end
        if (ACTIVE_LINES != pvt_pkg::FRAME_ACTIVE_LINES) begin : gBadLines
            $error("active line count must be 1080");
        end
        if (VBLANK < pvt_pkg::VBLANK_MIN) begin : gBadVb
            $error("vertical blanking too short");
        end
        if (FRAME_MS < pvt_pkg::FRAME_PERIOD_MS_MIN || FRAME_MS > pvt_pkg::FRAME_PERIOD_MS_MAX) begin : gBadFrame
            $error("frame period out of range");
        end
        if (FRAME_HZ > pvt_pkg::FRAME_RATE_HZ_MAX) begin : gBadRate
            $error("frame rate too high");
        end
        if (LINE_TOTAL >= (1 << pvt_pkg::PIX_CNT_W) || FRAME_LINES >= (1 << pvt_pkg::LINE_CNT_W)) begin : gBadW
            $error("counter too narrow");
        end
    endgenerate

    localparam logic [pvt_pkg::PIX_CNT_W-1:0] PIX_LAST = pvt_pkg::PIX_CNT_W'(LINE_TOTAL - 1);
    localparam logic [pvt_pkg::PIX_CNT_W-1:0] PIX_ACT = pvt_pkg::PIX_CNT_W'(ACTIVE_SPAN);
    localparam logic [pvt_pkg::LINE_CNT_W-1:0] LINE_LAST = pvt_pkg::LINE_CNT_W'(FRAME_LINES - 1);
    localparam logic [pvt_pkg::LINE_CNT_W-1:0] LINE_ACT = pvt_pkg::LINE_CNT_W'(ACTIVE_LINES);
    localparam int PTR_W = (FIFO_D > 1) ? $clog2(FIFO_D) : 1;
    localparam int CNT_W = $clog2(FIFO_D + 1);
    localparam logic [CNT_W-1:0] FIFO_FULL = CNT_W'(FIFO_D);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_D - 1);

    // ------------------------------------------------------------
    // pixel clock divider
    // ------------------------------------------------------------
    // the pixel clock is ref_clk / 2; data moves on its falling edge so the
    // panel samples mid-bit on the rising edge. real rate is set by ref_clk.
    logic phase_q;
    logic tick;

    assign tick = phase_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end

    // ------------------------------------------------------------
    // two-entry input buffer
    // ------------------------------------------------------------
    logic [FIFO_W-1:0] mem_q [FIFO_D];
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;
    logic [CNT_W-1:0] count_q;
    logic push;
    logic pop;
    logic fifoValid;

    assign fifoValid = (count_q != '0);
    assign push = inValid && inReady;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            inReady <= 1'b0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == PTR_LAST) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == PTR_LAST) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
            inReady <= (count_q + CNT_W'(push) - CNT_W'(pop)) != FIFO_FULL;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    // ------------------------------------------------------------
    // pixel and line counters
    // ------------------------------------------------------------
    logic [pvt_pkg::PIX_CNT_W-1:0] pixCnt_q;
    logic [pvt_pkg::LINE_CNT_W-1:0] lineCnt_q;
    logic activeNow;
    logic lineEnd;
    logic frameEnd;
    logic frameStart;
    logic blackFrame_q;
    logic emitBlack;

    // the strobe falls after 960 pixels of every active line and stays low through the vertical blanking lines
    assign activeNow = run && (pixCnt_q < PIX_ACT) && (lineCnt_q < LINE_ACT);
    assign lineEnd = (pixCnt_q == PIX_LAST);
    assign frameEnd = lineEnd && (lineCnt_q == LINE_LAST);
    assign frameStart = (pixCnt_q == '0) && (lineCnt_q == '0);
    assign emitBlack = blackFrame_q || (frameStart && blackReq);
    assign pop = tick && activeNow && fifoValid && !emitBlack;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pixCnt_q <= '0;
            lineCnt_q <= '0;
        end else if (tick) begin
            if (!run) begin
                // synchronous clear makes the source start at pixel 0 of line 0 once run rises; run itself gates the strobe
                pixCnt_q <= '0;
                lineCnt_q <= '0;
            end else if (lineEnd) begin
                pixCnt_q <= '0;
                lineCnt_q <= frameEnd ? '0 : lineCnt_q + 1'b1;
            end else begin
                pixCnt_q <= pixCnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // pixel output and black-frame handling
    // ------------------------------------------------------------
    pvt_pkg::pvt_pix_t pixNext;
    pvt_pkg::pvt_rgb_t fifoRgb;

    // channel order in the word: red high byte, blue low byte
    assign fifoRgb = pvt_pkg::pvt_rgb_t'(mem_q[rdPtr_q]);
    assign pixNext.strobe = activeNow;
    assign pixNext.rgb = pop ? fifoRgb : pvt_pkg::RGB_BLACK;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pixOut <= pvt_pkg::PIX_RESET;
            pixelClk <= 1'b0;
            blackFrame_q <= 1'b0;
            blackDone <= 1'b0;
            underrun <= 1'b0;
        end else begin
            pixelClk <= ~phase_q;
            if (tick) begin
                pixOut <= pixNext;
                if (!run) begin
                    blackFrame_q <= 1'b0;
                end else if (frameStart) begin
                    // request is taken only at a frame boundary so a frame is never half black
                    blackFrame_q <= blackReq;
                end
            end
            // the clear follows the request at once, not the slower pixel tick
            if (!blackReq) begin
                blackDone <= 1'b0;
            end else if (tick && run && frameEnd && blackFrame_q) begin
                blackDone <= 1'b1;
            end
            // set wins over the clear taken when run goes low
            if (tick && activeNow && !fifoValid && !emitBlack) begin
                underrun <= 1'b1;
            end else if (!run) begin
                underrun <= 1'b0;
            end
        end
    end

endmodule

// *** testbench/pvt_video_source_checker.sv ***
module pvt_video_source_checker #(
    parameter int ACTIVE_SPAN = pvt_pkg::LINE_ACTIVE_SPAN,
    parameter int HBLANK = pvt_pkg::HBLANK_NOM,
    parameter int FIFO_W = pvt_pkg::RGB_W
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic blackReq,
    input wire logic [FIFO_W-1:0] inData,
    input wire logic inValid,
    input wire logic inReady,
    input wire logic pixelClk,
    input wire pvt_pkg::pvt_pix_t pixOut,
    input wire logic underrun,
    input wire logic blackDone
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    // loCnt_q saturates, so a vertical blank cannot wrap into a false line gap
    logic [15:0] hiCnt_q, loCnt_q;
    logic seen_q;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hiCnt_q <= '0;
            loCnt_q <= '0;
            seen_q <= 1'h0;
        end else begin
            hiCnt_q <= pixOut.strobe ? hiCnt_q + 16'h1 : 16'h0;
            loCnt_q <= pixOut.strobe ? 16'h0 : loCnt_q + 16'(loCnt_q != 16'hFFFF);
            seen_q <= run && (seen_q || $fell(pixOut.strobe));
        end
    end
    a_pix_clk_toggle: assert property (
        run |-> pixelClk != $past(pixelClk)) else $error("pixel clock did not toggle");
    a_out_on_fall: assert property (
        !$fell(pixelClk) |-> $stable(pixOut)) else $error("pixel changed off a falling pixel clock");
    a_active_span: assert property (
        $fell(pixOut.strobe) && run && $past(run) |-> hiCnt_q == 16'(2 * ACTIVE_SPAN))
        else $error("active span length wrong");
    a_blank_span: assert property (
        $rose(pixOut.strobe) && seen_q && loCnt_q < 16'(2 * (ACTIVE_SPAN + HBLANK))
        |-> loCnt_q == 16'(2 * HBLANK)) else $error("line blanking length wrong");
    a_strobe_idle: assert property (
        !run [*4] |-> !pixOut.strobe) else $error("strobe high while stopped");
    a_underrun_hold: assert property (
        underrun && run |=> underrun) else $error("underrun flag dropped");
    a_underrun_clear: assert property (
        !run [*2] |-> !underrun) else $error("underrun flag kept while stopped");
    a_hold_full: assert property (
        !inReady ##0 (run && !pixOut.strobe) [*4] |-> !inReady) else $error("word taken in blanking");
    a_black_clear: assert property (
        !blackReq [*2] |-> !blackDone) else $error("black done without request");
endmodule

bind pvt_video_source pvt_video_source_checker #(.ACTIVE_SPAN(ACTIVE_SPAN), .HBLANK(HBLANK), .FIFO_W(FIFO_W))
    pvt_video_source_checker_inst (.ref_clk(ref_clk), .resetn(resetn), .run(run), .blackReq(blackReq),
    .inData(inData), .inValid(inValid), .inReady(inReady), .pixelClk(pixelClk), .pixOut(pixOut),
    .underrun(underrun), .blackDone(blackDone));

// *** testbench/pvt_panel_model.sv ***
module pvt_panel_model (
    input wire logic pixelClk,
    input wire logic clear,
    input wire pvt_pkg::pvt_pix_t pixOut
);
    timeunit 1ns;
    timeprecision 1ps;
    int hiRun, loRun, lastHigh, lastLow, lines;
    logic prevStrobe;
    pvt_pkg::pvt_rgb_t rxq[$];
    always @(posedge pixelClk) begin
        if (clear) begin
            {hiRun, loRun, lastHigh, lastLow, lines} = '0;
            prevStrobe = 1'h0;
            rxq.delete();
        end else if (pixOut.strobe) begin
            if (!prevStrobe) begin
                lines++;
                lastLow = loRun;
                hiRun = 0;
            end
            hiRun++;
            rxq.push_back(pixOut.rgb);
        end else begin
            if (prevStrobe) begin
                lastHigh = hiRun;
                loRun = 0;
            end
            loRun++;
        end
        prevStrobe = pixOut.strobe;
    end
endmodule

// *** testbench/pvt_video_source_test.sv ***
module pvt_video_source_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0, resetn = 1'h0, run = 1'h0, blackReq = 1'h0, feed = 1'h0, clear = 1'h0;
    logic inValid = 1'h0, inReady, pixelClk, underrun, blackDone, sawFull = 1'h0;
    logic [23:0] inData = 24'h0;
    pvt_pkg::pvt_pix_t pixOut;
    int sent = 0, mismatches = 0, checked = 0;
    pvt_video_source pvt_video_source_inst (.ref_clk(ref_clk), .resetn(resetn), .run(run),
        .blackReq(blackReq), .inData(inData), .inValid(inValid), .inReady(inReady),
        .pixelClk(pixelClk), .pixOut(pixOut), .underrun(underrun), .blackDone(blackDone));
    pvt_panel_model pvt_panel_model_inst (.pixelClk(pixelClk), .clear(clear), .pixOut(pixOut));
    always #50 ref_clk = ~ref_clk;
    // words are held until taken, so a refused word is offered again unchanged
    always @(posedge ref_clk) if (inValid && inReady) sent <= sent + 1;
    always @(posedge ref_clk) if (run && inReady === 1'h0) sawFull <= 1'h1;
    always @(negedge ref_clk) begin
        inValid <= feed;
        inData <= word(sent);
    end
    function automatic logic [23:0] word(input int n);
        return {n[7:0], n[7:0] ^ 8'h5A, n[15:8]};
    endfunction
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'h1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic wait_lines(input int n);
        int k;
        k = 0;
        while (pvt_panel_model_inst.lines < n && k < 3000 * n) begin
            @(negedge ref_clk);
            k++;
        end
        check(pvt_panel_model_inst.lines >= n, "line count not reached");
    endtask
    task automatic start(input logic blk);
        @(negedge ref_clk);
        clear = 1'h1;
        blackReq = blk;
        feed = 1'h1;
        repeat (4) @(negedge ref_clk);
        clear = 1'h0;
        run = 1'h1;
    endtask
    task automatic stop();
        run = 1'h0;
        feed = 1'h0;
        blackReq = 1'h0;
        repeat (6) @(negedge ref_clk);
        check(pixOut.strobe === 1'h0, "strobe high while stopped");
    endtask
    task automatic test_line();
        int base, bad, hi, lo;
        base = sent;
        start(1'h0);
        wait_lines(3);
        bad = 0;
        for (int i = 0; i < 2 * pvt_pkg::LINE_ACTIVE_SPAN; i++) begin
            if (pvt_panel_model_inst.rxq[i] !== word(base + i)) bad++;
        end
        check(bad == 0, "pixel order or value wrong");
        hi = pvt_panel_model_inst.lastHigh;
        lo = pvt_panel_model_inst.lastLow;
        check(hi == pvt_pkg::LINE_ACTIVE_SPAN, "active span wrong");
        check(lo == pvt_pkg::HBLANK_NOM, "blanking span wrong");
        check(hi + lo == pvt_pkg::LINE_PERIOD_TOTAL_NOM, "line total wrong");
        check(sawFull && underrun === 1'h0, "buffer never refused or underran");
        stop();
        $display("test_line done");
    endtask
    task automatic test_underrun();
        start(1'h0);
        wait_lines(1);
        feed = 1'h0;
        wait_lines(2);
        check(underrun === 1'h1, "underrun not flagged");
        check(pvt_panel_model_inst.rxq[$] === pvt_pkg::RGB_BLACK, "starved pixel not black");
        stop();
        check(underrun === 1'h0, "underrun not cleared");
        $display("test_underrun done");
    endtask
    task automatic test_black();
        int base, bad;
        start(1'h1);
        base = sent;
        wait_lines(2);
        bad = 0;
        foreach (pvt_panel_model_inst.rxq[i]) begin
            if (pvt_panel_model_inst.rxq[i] !== pvt_pkg::RGB_BLACK) bad++;
        end
        check(bad == 0 && sent - base <= pvt_pkg::FIFO_DEPTH, "black frame not black");
        check(blackDone === 1'h0, "black frame reported early");
        stop();
        $display("test_black done");
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        check(pixOut === pvt_pkg::PIX_RESET && inReady === 1'h0, "outputs not idle in reset");
        resetn = 1'h1;
        repeat (2) @(negedge ref_clk);
        check(inReady === 1'h1, "buffer not ready after reset");
        $display("test_reset done");
        test_line();
        test_underrun();
        test_black();
        finish_test();
    end
endmodule
